/* hw/fbcd_decoder.sv */
// Command-sequence decoder of a dual-bank NOR flash: power saving,
// sector locks, reset, autoselect reads and word programming.
// Assumes all pins are synchronous to clk and that the array and the
// program engine sit outside, reached through the array ports.
// Behaviour
// - Power saving starts off; unlock, unlock, 555h/70h enables it.
// - Power saving, once on, clears only on hardware reset.
// - All sectors locked after reset; unlock needs the lock sequence.
// - Lock: 60h, 60h, then sector address with 60h; line 6 picks lock.
// - Lock sequence persists for more sectors until a write without 60h, such as reset F0h.
// - Write protect low forces the two outermost boot sectors locked; here boost elevated overrides it and unlocks them.
// - Boost input low locks all sectors; elevated unlocks all.
// - Reset command returns the bank its address selects to read or suspend-read.
// - Reset aborts an erase sequence; ignored once erase runs.
// - Reset aborts a program sequence; ignored once programming runs.
// - Reset aborts autoselect entry; autoselect exits only by reset.
// - After timeout flag, reset command returns banks to read mode.
// - Unlock, unlock, bank address with 90h; then repeated ID reads.
// - Offset 00h gives maker code; 01h, 0Eh, 0Fh the device code.
// - Sector plus 02h reads 0001 if locked, 0000 if unlocked.
// - Program is four writes; the last launches the internal algorithm.
// - On finish bank returns to read, drops address; status bits report.
// - Commands ignored during programming; hardware reset aborts it.
// - Programming only clears bits; ones cannot be restored.
// - Program addresses may come in any order, across sectors.
// - Address latches on address-valid rise, data on write-strobe rise.
// - Invalid or out-of-order writes abort the sequence to array read.
`timescale 1ns/1ps
`default_nettype none

module fbcd_decoder #(
    // Arbitrary identification values.
    parameter logic [15:0] MANUF_CODE = 16'h00A5,
    parameter logic [15:0] DEV_CODE1 = 16'h1111,
    parameter logic [15:0] DEV_CODE2 = 16'h2222,
    parameter logic [15:0] DEV_CODE3 = 16'h3333
) (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Host bus cycle pins
    input wire logic address_valid_n,
    input wire logic write_strobe_n,
    input wire logic output_enable_n,
    input wire logic [fbcd_pkg::ADDR_W-1:0] addr_in,
    input wire logic [fbcd_pkg::DATA_W-1:0] data_in,
    // Protection pins
    input wire logic write_protect_n,
    input wire logic boost_low,
    input wire logic boost_high,
    // Program engine and array
    input wire logic [fbcd_pkg::NUM_BANKS-1:0] prog_done,
    input wire logic [fbcd_pkg::NUM_BANKS-1:0] prog_timeout,
    input wire logic [fbcd_pkg::NUM_BANKS-1:0] erase_busy,
    input wire logic [fbcd_pkg::NUM_BANKS-1:0] erase_suspended,
    input wire logic [fbcd_pkg::DATA_W-1:0] array_word,
    output logic prog_req,
    output var fbcd_pkg::fbcd_cycle_type prog_word,
    // Read path
    output logic [fbcd_pkg::DATA_W-1:0] rd_data,
    output logic rd_from_array,
    // Status
    output logic power_saving,
    output var fbcd_pkg::fbcd_mode_type [fbcd_pkg::NUM_BANKS-1:0] bank_mode,
    output logic data_polling_bit,
    output logic toggle_bit,
    output logic alternate_toggle_bit,
    output logic timeout_error_flag
);
    logic avd_q;
    logic we_q;
    logic oe_q;
    logic [fbcd_pkg::ADDR_W-1:0] addr_latched;
    logic [fbcd_pkg::NUM_SECTORS-1:0] sector_locked;
    fbcd_pkg::fbcd_seq_type seq;
    fbcd_pkg::fbcd_seq_type next_seq;
    logic [fbcd_pkg::NUM_BANKS-1:0] prog_bank_mask;
    logic wr_evt;
    logic rd_done;
    fbcd_pkg::fbcd_cycle_type cyc;
    logic sel_bank;
    logic sel_busy;
    logic is_reset;
    logic low_is_cmd;
    logic [7:0] sel_sector;
    logic sel_locked;
    logic do_ps;
    logic do_autosel;
    logic do_prog;
    logic do_lock;

    function automatic logic [7:0] sector_of(input logic [fbcd_pkg::ADDR_W-1:0] a);
        if (a[21:15] == fbcd_pkg::SMALL_REGION)
            return fbcd_pkg::SMALL_BASE + {5'h00, a[14:12]};
        return {1'b0, a[21:15]};
    endfunction

    function automatic logic bank_of(input logic [fbcd_pkg::ADDR_W-1:0] a);
        return a[21:20] == fbcd_pkg::BANK_A_TOP;
    endfunction

    // Effective lock of one sector after both protection pins.
    function automatic logic locked_eff(input logic [7:0] s,
                                        input logic [fbcd_pkg::NUM_SECTORS-1:0] sw,
                                        input logic wp_n, input logic bl,
                                        input logic bh);
        if (bl || bh)
            return bl;
        return sw[s] | (!wp_n && s >= fbcd_pkg::BOOT_FIRST);
    endfunction

    // Pins are synchronous, so one register gives the rising edges.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            avd_q <= 1'b1;
            we_q <= 1'b1;
            oe_q <= 1'b1;
        end
        else
        begin
            avd_q <= address_valid_n;
            we_q <= write_strobe_n;
            oe_q <= output_enable_n;
        end
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            addr_latched <= '0;
        else if (address_valid_n && !avd_q)
            addr_latched <= addr_in;
    end

    // A write cycle completes on the write strobe rise with its data.
    assign wr_evt = write_strobe_n && !we_q;
    assign rd_done = output_enable_n && !oe_q;
    assign cyc.addr = addr_latched;
    assign cyc.data = data_in;
    assign sel_bank = bank_of(cyc.addr);
    assign sel_sector = sector_of(cyc.addr);
    assign sel_locked = locked_eff(sel_sector, sector_locked, write_protect_n,
                                   boost_low, boost_high);
    assign is_reset = cyc.data[7:0] == fbcd_pkg::CMD_RESET;
    assign low_is_cmd = cyc.addr[11:0] == fbcd_pkg::ADDR_CMD;
    // Writes to a bank that is programming or erasing never reach the sequencer.
    assign sel_busy = bank_mode[sel_bank] == fbcd_pkg::MODE_PROGRAM
                      || erase_busy[sel_bank];

    always_comb
    begin
        next_seq = fbcd_pkg::SEQ_IDLE;
        do_ps = 1'b0;
        do_autosel = 1'b0;
        do_prog = 1'b0;
        do_lock = 1'b0;
        case (seq)
            fbcd_pkg::SEQ_IDLE:
                if (cyc.addr[11:0] == fbcd_pkg::ADDR_UNLOCK1
                    && cyc.data[7:0] == fbcd_pkg::DATA_UNLOCK1)
                    next_seq = fbcd_pkg::SEQ_UNLOCK1;
                else if (cyc.data[7:0] == fbcd_pkg::CMD_LOCK)
                    next_seq = fbcd_pkg::SEQ_LOCK1;
            fbcd_pkg::SEQ_UNLOCK1:
                if (cyc.addr[11:0] == fbcd_pkg::ADDR_UNLOCK2
                    && cyc.data[7:0] == fbcd_pkg::DATA_UNLOCK2)
                    next_seq = fbcd_pkg::SEQ_UNLOCK2;
            fbcd_pkg::SEQ_UNLOCK2:
                if (low_is_cmd && cyc.data[7:0] == fbcd_pkg::CMD_POWER_SAVE)
                    do_ps = 1'b1;
                else if (low_is_cmd && cyc.data[7:0] == fbcd_pkg::CMD_AUTOSELECT)
                    do_autosel = 1'b1;
                else if (low_is_cmd && cyc.data[7:0] == fbcd_pkg::CMD_PROGRAM)
                    next_seq = fbcd_pkg::SEQ_PROG;
            // A reset here aborts; a locked target is dropped silently.
            fbcd_pkg::SEQ_PROG:
                do_prog = !is_reset && !sel_locked;
            fbcd_pkg::SEQ_LOCK1:
                if (cyc.data[7:0] == fbcd_pkg::CMD_LOCK)
                    next_seq = fbcd_pkg::SEQ_LOCK2;
            fbcd_pkg::SEQ_LOCK2:
                if (cyc.data[7:0] == fbcd_pkg::CMD_LOCK)
                begin
                    do_lock = 1'b1;
                    next_seq = fbcd_pkg::SEQ_LOCK2;
                end
            default:
                next_seq = fbcd_pkg::SEQ_IDLE;
        endcase
    end

    // Anything not matched above falls back to idle, aborting the sequence.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            seq <= fbcd_pkg::SEQ_IDLE;
        else if (wr_evt && !sel_busy)
            seq <= next_seq;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            power_saving <= 1'b0;
        else if (wr_evt && !sel_busy && do_ps)
            power_saving <= 1'b1;
    end

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            sector_locked <= '1;
        else if (wr_evt && !sel_busy && do_lock)
            sector_locked[sel_sector] <= !cyc.addr[fbcd_pkg::LOCK_SELECT_BIT];
    end

    // Per-bank mode. A hardware reset drops programming at once.
    for (genvar b = 0; b < fbcd_pkg::NUM_BANKS; b++)
    begin : g_bank
        logic hit;
        fbcd_pkg::fbcd_mode_type rest;
        assign hit = wr_evt && sel_bank == b[0];
        assign rest = erase_suspended[b] ? fbcd_pkg::MODE_SUSPEND_READ
                                         : fbcd_pkg::MODE_READ;
        always_ff @(posedge clk or negedge nrst)
        begin
            if (!nrst)
            begin
                bank_mode[b] <= fbcd_pkg::MODE_READ;
            end
            else
            begin
                case (bank_mode[b])
                    fbcd_pkg::MODE_PROGRAM:
                        if (prog_done[b])
                            bank_mode[b] <= rest;
                        else if (hit && is_reset && prog_timeout[b])
                            bank_mode[b] <= rest;
                    fbcd_pkg::MODE_AUTOSELECT:
                        if (hit && is_reset)
                            bank_mode[b] <= rest;
                    default:
                        if (hit && !erase_busy[b] && do_prog)
                            bank_mode[b] <= fbcd_pkg::MODE_PROGRAM;
                        else if (hit && !erase_busy[b] && do_autosel)
                            bank_mode[b] <= fbcd_pkg::MODE_AUTOSELECT;
                        else
                            bank_mode[b] <= rest;
                endcase
            end
        end
    end

    // Program launch; the word ANDs with the current contents.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            prog_req <= 1'b0;
            prog_word <= '0;
            prog_bank_mask <= '0;
        end
        else
        begin
            prog_req <= 1'b0;
            if (wr_evt && !sel_busy && do_prog)
            begin
                prog_req <= 1'b1;
                prog_word.addr <= cyc.addr;
                prog_word.data <= cyc.data & array_word;
                prog_bank_mask[sel_bank] <= 1'b1;
            end
            else if ((prog_done & prog_bank_mask) != '0)
            begin
                prog_word <= '0;
                prog_bank_mask <= '0;
            end
        end
    end

    // Read answer for the latched address, one cycle later.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rd_data <= '0;
            rd_from_array <= 1'b1;
        end
        else
        begin
            rd_from_array <= 1'b0;
            rd_data <= '0;
            if (bank_mode[bank_of(addr_latched)] == fbcd_pkg::MODE_AUTOSELECT)
            begin
                case (addr_latched[7:0])
                    fbcd_pkg::OFS_MANUF: rd_data <= MANUF_CODE;
                    fbcd_pkg::OFS_DEV1: rd_data <= DEV_CODE1;
                    fbcd_pkg::OFS_DEV2: rd_data <= DEV_CODE2;
                    fbcd_pkg::OFS_DEV3: rd_data <= DEV_CODE3;
                    fbcd_pkg::OFS_HANDSHAKE: rd_data <= fbcd_pkg::HANDSHAKE_WORD;
                    fbcd_pkg::OFS_LOCK:
                    begin
                        rd_data <= locked_eff(sector_of(addr_latched), sector_locked,
                                              write_protect_n, boost_low, boost_high)
                                   ? fbcd_pkg::LOCKED_WORD
                                   : fbcd_pkg::UNLOCKED_WORD;
                    end
                    default: rd_data <= '0;
                endcase
            end
            else if (bank_mode[bank_of(addr_latched)] != fbcd_pkg::MODE_PROGRAM)
            begin
                rd_from_array <= 1'b1;
            end
        end
    end

    // Status bits of the running program operation.
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            data_polling_bit <= 1'b0;
            toggle_bit <= 1'b0;
            alternate_toggle_bit <= 1'b0;
            timeout_error_flag <= 1'b0;
        end
        else if ((prog_bank_mask & ~prog_done) != '0)
        begin
            data_polling_bit <= !prog_word.data[fbcd_pkg::POLL_BIT];
            timeout_error_flag <= (prog_timeout & prog_bank_mask) != '0;
            if (rd_done)
            begin
                toggle_bit <= !toggle_bit;
                alternate_toggle_bit <= !alternate_toggle_bit;
            end
        end
        else
        begin
            data_polling_bit <= prog_word.data[fbcd_pkg::POLL_BIT];
            timeout_error_flag <= 1'b0;
        end
    end
endmodule

`default_nettype wire

/* hw/fbcd_pkg.sv */
// Constants and types of the flash bank command decoder.
// Assumes a 22-bit word address and 16-bit command data.
package fbcd_pkg;
    localparam int ADDR_W = 22;
    localparam int DATA_W = 16;
    localparam int NUM_SECTORS = 135;
    localparam int NUM_BANKS = 2;
    // Command addresses compare on the low twelve bits.
    localparam logic [11:0] ADDR_UNLOCK1 = 12'h555;
    localparam logic [11:0] ADDR_UNLOCK2 = 12'h2AA;
    localparam logic [11:0] ADDR_CMD = 12'h555;
    localparam logic [7:0] DATA_UNLOCK1 = 8'hAA;
    localparam logic [7:0] DATA_UNLOCK2 = 8'h55;
    localparam logic [7:0] CMD_POWER_SAVE = 8'h70;
    localparam logic [7:0] CMD_LOCK = 8'h60;
    localparam logic [7:0] CMD_RESET = 8'hF0;
    localparam logic [7:0] CMD_AUTOSELECT = 8'h90;
    localparam logic [7:0] CMD_PROGRAM = 8'hA0;
    // Bank A holds addresses 300000h and up.
    localparam logic [1:0] BANK_A_TOP = 2'h3;
    localparam int LOCK_SELECT_BIT = 6;
    // Sector map: 32 Kword sectors, then eight 4 Kword boot sectors.
    localparam logic [6:0] SMALL_REGION = 7'h7F;
    localparam logic [7:0] SMALL_BASE = 8'h7F;
    localparam logic [7:0] BOOT_FIRST = 8'h85;
    // Autoselect offsets within a bank.
    localparam logic [7:0] OFS_MANUF = 8'h00;
    localparam logic [7:0] OFS_DEV1 = 8'h01;
    localparam logic [7:0] OFS_LOCK = 8'h02;
    localparam logic [7:0] OFS_HANDSHAKE = 8'h03;
    localparam logic [7:0] OFS_DEV2 = 8'h0E;
    localparam logic [7:0] OFS_DEV3 = 8'h0F;
    localparam logic [15:0] LOCKED_WORD = 16'h0001;
    localparam logic [15:0] UNLOCKED_WORD = 16'h0000;
    localparam logic [15:0] HANDSHAKE_WORD = 16'h0040;
    localparam int POLL_BIT = 7;

    typedef enum logic [1:0] {
        MODE_READ,
        MODE_SUSPEND_READ,
        MODE_AUTOSELECT,
        MODE_PROGRAM
    } fbcd_mode_type;

    typedef enum logic [2:0] {
        SEQ_IDLE,
        SEQ_UNLOCK1,
        SEQ_UNLOCK2,
        SEQ_PROG,
        SEQ_LOCK1,
        SEQ_LOCK2
    } fbcd_seq_type;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fbcd_cycle_type;
endpackage

/* tb/fbcd_host.sv */
// Behavioural host memory controller driving flash bus cycles.
// Assumes a free-running clk; the bench calls its tasks hierarchically.
`timescale 1ns/1ps
`default_nettype none

module fbcd_host (
    // Clock
    input wire logic clk,
    // Bus cycle pins
    output logic address_valid_n,
    output logic write_strobe_n,
    output logic output_enable_n,
    output logic [fbcd_pkg::ADDR_W-1:0] addr_in,
    output logic [fbcd_pkg::DATA_W-1:0] data_in
);
    initial
    begin
        address_valid_n = 1'b1;
        write_strobe_n = 1'b1;
        output_enable_n = 1'b1;
        addr_in = 22'h000000;
        data_in = 16'h0000;
    end

    // Each strobe level spans a full clock so the decoder always sees the rise.
    task automatic adr(input logic [21:0] a);
        @(posedge clk);
        address_valid_n <= 1'b0;
        addr_in <= a;
        @(posedge clk);
        address_valid_n <= 1'b1;
    endtask

    task automatic wr(input logic [21:0] a, input logic [15:0] d);
        adr(a);
        @(posedge clk);
        write_strobe_n <= 1'b0;
        data_in <= d;
        @(posedge clk);
        write_strobe_n <= 1'b1;
        @(posedge clk);
        // Released lines show the inverse so a stale value cannot pass for a live one.
        addr_in <= ~a;
        data_in <= ~d;
        #1;
    endtask

    task automatic unl(input logic [9:0] hi);
        wr({hi, fbcd_pkg::ADDR_UNLOCK1}, {8'h00, fbcd_pkg::DATA_UNLOCK1});
        wr({hi, fbcd_pkg::ADDR_UNLOCK2}, {8'h00, fbcd_pkg::DATA_UNLOCK2});
    endtask

    task automatic cmd(input logic [9:0] hi, input logic [7:0] c);
        unl(hi);
        wr({hi, fbcd_pkg::ADDR_CMD}, {8'h00, c});
    endtask

    task automatic rd(input logic [21:0] a);
        adr(a);
        @(posedge clk);
        output_enable_n <= 1'b0;
        @(posedge clk);
        output_enable_n <= 1'b1;
        addr_in <= ~a;
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* tb/fbcd_props.sv */
// Concurrent checks on the decoder's ports, attached by bind.
// Assumes one clock domain with nrst as its asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none

module fbcd_props (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Host and protection pins
    input wire logic write_strobe_n,
    input wire logic [fbcd_pkg::DATA_W-1:0] data_in,
    input wire logic write_protect_n,
    input wire logic boost_low,
    // Program engine
    input wire logic [fbcd_pkg::NUM_BANKS-1:0] prog_done,
    input wire logic [fbcd_pkg::NUM_BANKS-1:0] prog_timeout,
    input wire logic [fbcd_pkg::NUM_BANKS-1:0] erase_suspended,
    input wire logic prog_req,
    input wire fbcd_pkg::fbcd_cycle_type prog_word,
    // Status
    input wire logic power_saving,
    input wire fbcd_pkg::fbcd_mode_type [fbcd_pkg::NUM_BANKS-1:0] bank_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_launch;
        prog_req ##1 !prog_req;
    endsequence
    sequence s_done_a;
        prog_done[1] && bank_mode[1] == fbcd_pkg::MODE_PROGRAM;
    endsequence
    sequence s_busy_a;
        bank_mode[1] == fbcd_pkg::MODE_PROGRAM && !prog_done[1] && !prog_timeout[1];
    endsequence

    a_ps_sticky: assert property (power_saving |=> power_saving)
        else $error("power saving dropped without reset");
    a_ps_cause: assert property ($rose(power_saving) |-> $past(write_strobe_n)
        && !$past(write_strobe_n, 2) && $past(data_in[7:0]) == fbcd_pkg::CMD_POWER_SAVE)
        else $error("power saving rose without its command");
    a_prog_pulse: assert property ($rose(prog_req) |-> s_launch)
        else $error("program request longer than one cycle");
    a_prog_mode: assert property (prog_req |-> (prog_word.addr[21:20] ==
        fbcd_pkg::BANK_A_TOP ? bank_mode[1] : bank_mode[0]) == fbcd_pkg::MODE_PROGRAM)
        else $error("program launched without bank in program mode");
    a_done_read: assert property (s_done_a |=> bank_mode[1] != fbcd_pkg::MODE_PROGRAM
        && bank_mode[1] != fbcd_pkg::MODE_AUTOSELECT && prog_word == '0)
        else $error("bank not back in read after program done");
    a_prog_stays: assert property (s_busy_a |=> bank_mode[1] == fbcd_pkg::MODE_PROGRAM)
        else $error("program mode left before completion");
    a_mode_cause: assert property ($changed(bank_mode) |->
        ($past(write_strobe_n) && !$past(write_strobe_n, 2)) || $past(prog_done) != 2'h0
        || $past(erase_suspended) != $past(erase_suspended, 2))
        else $error("bank mode changed without a write or completion");
    a_boost_lock: assert property (prog_req |-> !$past(boost_low))
        else $error("program launched while boost input low");
    a_wp_lock: assert property (prog_req |-> $past(write_protect_n)
        || prog_word.addr[21:13] != 9'h1FF)
        else $error("program launched into protected boot sector");
endmodule

bind fbcd_decoder fbcd_props props_u (
    .clk(clk), .nrst(nrst), .write_strobe_n(write_strobe_n), .data_in(data_in),
    .write_protect_n(write_protect_n), .boost_low(boost_low), .prog_done(prog_done),
    .prog_timeout(prog_timeout), .erase_suspended(erase_suspended), .prog_req(prog_req),
    .prog_word(prog_word), .power_saving(power_saving), .bank_mode(bank_mode)
);
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the flash bank command decoder.
// Assumes the host model drives the bus; the bench plays program engine and pins.
`timescale 1ns/1ps
`default_nettype none

module tb;
    // Identification values are arbitrary.
    localparam logic [15:0] MANUF = 16'h005A;
    localparam logic [15:0] DEV1 = 16'h0A11;
    localparam logic [15:0] DEV2 = 16'h0B22;
    localparam logic [15:0] DEV3 = 16'h0C33;
    typedef struct packed {logic [21:0] addr; logic [15:0] exp;} fbcd_row_type;
    localparam fbcd_row_type ROWS [6] = '{'{22'h000000, MANUF}, '{22'h000001, DEV1},
        '{22'h00000E, DEV2}, '{22'h00000F, DEV3}, '{22'h000003, 16'h0040},
        '{22'h208002, 16'h0001}};

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic wp_n, boost_low, boost_high;
    logic [1:0] prog_done, prog_timeout, erase_busy, erase_suspended;
    logic [15:0] array_word;
    logic avd_n, we_n, oe_n, prog_req, rd_from_array, power_saving;
    logic poll, toggle, alt_toggle, timeout_error_flag;
    logic [21:0] addr_in;
    logic [15:0] data_in, rd_data;
    fbcd_pkg::fbcd_cycle_type prog_word;
    fbcd_pkg::fbcd_mode_type [1:0] bank_mode;
    int mismatches = 0;
    int checks_done = 0;
    int cycles = 0;

    always #12.5 clk = ~clk;

    fbcd_host host_u (.clk(clk), .address_valid_n(avd_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .addr_in(addr_in), .data_in(data_in));

    fbcd_decoder #(.MANUF_CODE(MANUF), .DEV_CODE1(DEV1), .DEV_CODE2(DEV2),
        .DEV_CODE3(DEV3)) dut_u (
        .clk(clk), .nrst(nrst), .address_valid_n(avd_n), .write_strobe_n(we_n),
        .output_enable_n(oe_n), .addr_in(addr_in), .data_in(data_in),
        .write_protect_n(wp_n), .boost_low(boost_low), .boost_high(boost_high),
        .prog_done(prog_done), .prog_timeout(prog_timeout), .erase_busy(erase_busy),
        .erase_suspended(erase_suspended), .array_word(array_word), .prog_req(prog_req),
        .prog_word(prog_word), .rd_data(rd_data), .rd_from_array(rd_from_array),
        .power_saving(power_saving), .bank_mode(bank_mode), .data_polling_bit(poll),
        .toggle_bit(toggle), .alternate_toggle_bit(alt_toggle),
        .timeout_error_flag(timeout_error_flag));

    task automatic chk(input logic [37:0] seen, input logic [37:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic prog(input logic [21:0] a, input logic [15:0] d);
        host_u.cmd(10'h3FF, fbcd_pkg::CMD_PROGRAM);
        host_u.wr(a, d);
    endtask

    task automatic done_a;
        @(posedge clk) prog_done <= 2'h2;
        @(posedge clk) prog_done <= 2'h0;
        #1;
    endtask

    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 8000)
        begin
            mismatches++;
            test_done();
        end
    end

    initial
    begin
        {wp_n, boost_low, boost_high, array_word} <= {3'h4, 16'hFF0F};
        {prog_done, prog_timeout, erase_busy, erase_suspended} <= 8'h00;
        repeat (5) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(power_saving, 1'b0);
        chk(rd_from_array, 1'b1);
        chk(bank_mode, {fbcd_pkg::MODE_READ, fbcd_pkg::MODE_READ});
        host_u.cmd(10'h000, fbcd_pkg::CMD_POWER_SAVE);
        chk(power_saving, 1'b1);
        host_u.wr(22'h000000, 16'h00F0);
        chk(power_saving, 1'b1);
        $display("test power_save done");
        host_u.cmd(10'h000, fbcd_pkg::CMD_AUTOSELECT);
        chk(bank_mode[0], fbcd_pkg::MODE_AUTOSELECT);
        foreach (ROWS[i])
        begin
            host_u.rd(ROWS[i].addr);
            chk(rd_data, ROWS[i].exp);
        end
        host_u.wr(22'h0ABCDE, 16'h00F0);
        chk(bank_mode[0], fbcd_pkg::MODE_READ);
        $display("test autoselect done");
        host_u.wr(22'h3FF000, 16'h0060);
        host_u.wr(22'h3FF000, 16'h0060);
        host_u.wr(22'h3FF040, 16'h0060);
        host_u.wr(22'h320040, 16'h0060);
        host_u.wr(22'h328040, 16'h0060);
        host_u.wr(22'h328000, 16'h0060);
        host_u.wr(22'h3FF000, 16'h00F0);
        host_u.cmd(10'h3FF, fbcd_pkg::CMD_AUTOSELECT);
        host_u.rd(22'h3FF002);
        chk(rd_data, fbcd_pkg::UNLOCKED_WORD);
        host_u.rd(22'h320002);
        chk(rd_data, fbcd_pkg::UNLOCKED_WORD);
        host_u.rd(22'h328002);
        chk(rd_data, fbcd_pkg::LOCKED_WORD);
        host_u.rd(22'h310002);
        chk(rd_data, fbcd_pkg::LOCKED_WORD);
        @(posedge clk) wp_n <= 1'b0;
        host_u.rd(22'h3FF002);
        chk(rd_data, fbcd_pkg::LOCKED_WORD);
        @(posedge clk) wp_n <= 1'b1;
        @(posedge clk) boost_low <= 1'b1;
        host_u.rd(22'h320002);
        chk(rd_data, fbcd_pkg::LOCKED_WORD);
        @(posedge clk) boost_low <= 1'b0;
        @(posedge clk) boost_high <= 1'b1;
        host_u.rd(22'h310002);
        chk(rd_data, fbcd_pkg::UNLOCKED_WORD);
        @(posedge clk) boost_high <= 1'b0;
        host_u.wr(22'h300000, 16'h00F0);
        chk(bank_mode[1], fbcd_pkg::MODE_READ);
        $display("test locks done");
        prog(22'h320010, 16'h1234);
        chk(prog_req, 1'b1);
        chk(prog_word, {22'h320010, 16'h1204});
        host_u.wr(22'h300000, 16'h00F0);
        chk(bank_mode[1], fbcd_pkg::MODE_PROGRAM);
        chk(poll, 1'b1);
        host_u.rd(22'h320010);
        chk({toggle, alt_toggle, rd_from_array}, 3'h6);
        done_a();
        chk(bank_mode[1], fbcd_pkg::MODE_READ);
        chk(prog_word, 38'h0);
        prog(22'h3FF100, 16'h0000);
        chk(prog_req, 1'b1);
        done_a();
        host_u.unl(10'h3FF);
        host_u.wr(22'h3FF555, 16'h00A0);
        host_u.wr(22'h300000, 16'h00F0);
        host_u.wr(22'h320050, 16'h1234);
        chk(prog_req, 1'b0);
        prog(22'h310010, 16'h1234);
        chk(prog_req, 1'b0);
        chk(bank_mode[1], fbcd_pkg::MODE_READ);
        $display("test program done");
        host_u.wr(22'h000555, 16'h00AA);
        host_u.wr(22'h0002AA, 16'h0000);
        host_u.wr(22'h000555, 16'h0090);
        chk(bank_mode[0], fbcd_pkg::MODE_READ);
        @(posedge clk) erase_busy <= 2'h1;
        host_u.cmd(10'h000, fbcd_pkg::CMD_AUTOSELECT);
        chk(bank_mode[0], fbcd_pkg::MODE_READ);
        @(posedge clk) erase_busy <= 2'h0;
        @(posedge clk) erase_suspended <= 2'h1;
        host_u.cmd(10'h000, fbcd_pkg::CMD_AUTOSELECT);
        host_u.wr(22'h000000, 16'h00F0);
        chk(bank_mode[0], fbcd_pkg::MODE_SUSPEND_READ);
        @(posedge clk) erase_suspended <= 2'h0;
        prog(22'h320020, 16'h1234);
        @(posedge clk) prog_timeout <= 2'h2;
        repeat (2) @(posedge clk);
        #1;
        chk(timeout_error_flag, 1'b1);
        host_u.wr(22'h300000, 16'h00F0);
        chk(bank_mode[1], fbcd_pkg::MODE_READ);
        @(posedge clk) prog_timeout <= 2'h0;
        $display("test aborts done");
        prog(22'h320030, 16'h1234);
        chk(power_saving, 1'b1);
        @(posedge clk) nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk(bank_mode, {fbcd_pkg::MODE_READ, fbcd_pkg::MODE_READ});
        chk(power_saving, 1'b0);
        prog(22'h320030, 16'h1234);
        chk(prog_req, 1'b0);
        $display("test hard_reset done");
        test_done();
    end
endmodule
`default_nettype wire
